// ### tpac_pkg.sv
package tpac_pkg;

	// Register byte offsets
	localparam logic [7:0] REG_PWR_OFS  = 8'h00;
	localparam logic [7:0] REG_ATT_OFS  = 8'h04;
	localparam logic [7:0] REG_STAT_OFS = 8'h08;

	// Timing
	localparam int CLK_MHZ            = 100;
	localparam int SLEEP_PERIOD_US    = 100000;
	localparam int DEEP_PERIOD_US     = 1000000;
	localparam int SLOW_BASE_US       = 1000;
	localparam int PULSE_UNIT_NS      = 1000;
	localparam int SLEEP_CYCLES_DEF   = SLEEP_PERIOD_US * CLK_MHZ;
	localparam int DEEP_CYCLES_DEF    = DEEP_PERIOD_US * CLK_MHZ;
	localparam int SLOW_BASE_DEF      = SLOW_BASE_US * CLK_MHZ;
	localparam int PULSE_UNIT_CYCLES  = (PULSE_UNIT_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_W              = 27;
	localparam int PULSE_W            = 16;
	localparam logic [2:0] SLOW_MAX   = 3'h6;
	localparam logic [4:0] SETTLE_CNT = 5'h10;
	localparam int IDLE_SCALE_SH      = 4;

	// Reset values
	localparam logic [31:0] PWR_RST = 32'h0000_0000;
	localparam logic [31:0] ATT_RST = 32'h0000_0A0A;

	typedef enum logic [1:0] {
		PS_ACTIVE = 2'b00,
		PS_SLEEP  = 2'b01,
		PS_DEEP   = 2'b10,
		PS_FREEZE = 2'b11
	} tpac_pwr_e;

	typedef enum logic [1:0] {
		AM_PERIODIC = 2'b00,
		AM_MOVE     = 2'b01,
		AM_TOUCH    = 2'b10,
		AM_NONE     = 2'b11
	} tpac_att_e;

	typedef enum logic [1:0] {
		IS_IDLE = 2'b00,
		IS_ADDR = 2'b01,
		IS_DATA = 2'b10
	} tpac_i2c_e;

	typedef struct packed {
		logic [23:0] rsvd;
		logic [3:0]  idle_period;
		logic        rsvd3;
		logic        allow_sleep;
		tpac_pwr_e   power_mode;
	} tpac_pwr_s;

	typedef struct packed {
		logic [15:0] rsvd;
		logic [7:0]  pulse_width;
		logic [2:0]  rsvd2;
		logic        wake_on_attn;
		logic        en_attn;
		logic        attention_polarity;
		tpac_att_e   att_mode;
	} tpac_att_s;

endpackage

// ### tpac_sync.sv
`timescale 1ns/1ps
module tpac_sync
	import tpac_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic d,
	output logic      q
);

	logic s1;
	logic s2;
	logic s3;
	logic next_q;

	// Level is taken once the second and third stages agree
	always_comb begin
		next_q = q;
		if (s2 == s3) begin
			next_q = s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q  <= RST_VAL;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= next_q;
		end
	end

endmodule

// ### tpac_ctrl.sv
`timescale 1ns/1ps
module tpac_ctrl
	import tpac_pkg::*;
#(
	parameter int SLEEP_CYCLES = SLEEP_CYCLES_DEF,
	parameter int DEEP_CYCLES  = DEEP_CYCLES_DEF,
	parameter int SLOW_BASE    = SLOW_BASE_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic        rst_pin_n,
	input  wire logic        attn_in,
	output logic             attn_out,
	output logic             attn_oe,
	output logic             scan_start,
	input  wire logic        scan_done,
	input  wire logic        scan_finger,
	input  wire logic        scan_moving,
	output logic             osc_run
);

	localparam logic [GAP_W-1:0] SLEEP_GAP = GAP_W'(SLEEP_CYCLES);
	localparam logic [GAP_W-1:0] DEEP_GAP  = GAP_W'(DEEP_CYCLES);
	localparam logic [GAP_W-1:0] SLOW_GAP  = GAP_W'(SLOW_BASE);

	tpac_pwr_s        pwr;
	tpac_att_s        att;
	tpac_pwr_s        next_pwr;
	tpac_att_s        next_att;
	logic [31:0]      next_prdata;
	logic             scan_busy;
	logic             next_scan_busy;
	logic             next_scan_start;
	logic [GAP_W-1:0] gap_cnt;
	logic [GAP_W-1:0] next_gap_cnt;
	logic [7:0]       idle_cnt;
	logic [7:0]       next_idle_cnt;
	logic [2:0]       slow_shift;
	logic [2:0]       next_slow_shift;
	logic [4:0]       settle;
	logic [4:0]       next_settle;
	logic             attn_ref;
	logic             next_attn_ref;
	logic             hold;
	logic             next_hold;
	logic             pend;
	logic             next_pend;
	logic             last_finger;
	logic             next_last_finger;
	logic [PULSE_W-1:0] pulse_cnt;
	logic [PULSE_W-1:0] next_pulse_cnt;
	logic             next_attn_out;
	logic             next_attn_oe;
	logic             scl_s;
	logic             sda_s;
	logic             rst_s;
	logic             attn_s;
	logic             scl_d;
	logic             sda_d;
	tpac_i2c_e        i2c_st;
	tpac_i2c_e        next_i2c_st;
	logic [3:0]       bit_cnt;
	logic [3:0]       next_bit_cnt;
	logic             rd_dir;
	logic             next_rd_dir;
	logic             read_done;
	logic             apb_wr;
	logic             wr_pwr;
	logic             att_act;
	logic             frozen;
	logic             wake;

	tpac_sync #(.RST_VAL(1'b1)) u_scl  (.pclk(pclk), .presetn(presetn), .d(scl_in),    .q(scl_s));
	tpac_sync #(.RST_VAL(1'b1)) u_sda  (.pclk(pclk), .presetn(presetn), .d(sda_in),    .q(sda_s));
	tpac_sync #(.RST_VAL(1'b1)) u_rst  (.pclk(pclk), .presetn(presetn), .d(rst_pin_n), .q(rst_s));
	tpac_sync #(.RST_VAL(1'b1)) u_attn (.pclk(pclk), .presetn(presetn), .d(attn_in),   .q(attn_s));

	////////////////////////////////////////////////////////////////////////////////
	// APB slave and power state
	assign pready  = 1'b1;
	assign apb_wr  = psel & penable & pwrite;
	assign wr_pwr  = apb_wr & (paddr == REG_PWR_OFS);
	assign pslverr = psel & penable & (paddr != REG_PWR_OFS) & (paddr != REG_ATT_OFS)
		& (paddr != REG_STAT_OFS);
	assign frozen  = (pwr.power_mode == PS_FREEZE);
	assign osc_run = ~frozen;
	assign att_act = hold | (pulse_cnt != '0);
	assign wake    = frozen & (~rst_s | (att.wake_on_attn & (settle == SETTLE_CNT)
		& (attn_s != attn_ref)));

	always_comb begin
		next_pwr        = pwr;
		next_att        = att;
		next_prdata     = prdata;
		next_scan_busy  = scan_busy;
		next_scan_start = 1'b0;
		next_gap_cnt    = gap_cnt;
		next_idle_cnt   = idle_cnt;
		next_slow_shift = slow_shift;
		next_settle     = settle;
		next_attn_ref   = attn_ref;
		if (gap_cnt != '0) begin
			next_gap_cnt = gap_cnt - 1'b1;
		end
		if (scan_done) begin
			next_scan_busy = 1'b0;
			case (pwr.power_mode)
				PS_SLEEP: begin
					next_gap_cnt = SLEEP_GAP;
					if (pwr.allow_sleep && scan_finger) begin
						next_pwr.power_mode = PS_ACTIVE;
						next_gap_cnt        = '0;
					end
				end
				PS_DEEP: begin
					next_gap_cnt = DEEP_GAP;
				end
				PS_ACTIVE: begin
					if (scan_finger) begin
						next_idle_cnt   = '0;
						next_slow_shift = '0;
					end else begin
						next_idle_cnt = idle_cnt + 1'b1;
						if (pwr.allow_sleep && ({4'h0, pwr.idle_period} << IDLE_SCALE_SH)
							<= idle_cnt) begin
							next_pwr.power_mode = PS_SLEEP;
							next_idle_cnt       = '0;
						end
						if (!pend && slow_shift != SLOW_MAX) begin
							next_slow_shift = slow_shift + 1'b1;
						end
					end
					next_gap_cnt = (next_slow_shift == '0) ? '0 :
						GAP_W'(SLOW_GAP << (next_slow_shift - 1'b1));
				end
				default: begin
					next_gap_cnt = '0;
				end
			endcase
		end
		if (!scan_busy && gap_cnt == '0) begin
			if ((pwr.power_mode == PS_ACTIVE && !att_act) ||
				pwr.power_mode == PS_SLEEP || pwr.power_mode == PS_DEEP) begin
				next_scan_start = 1'b1;
				next_scan_busy  = 1'b1;
			end
		end
		if (frozen) begin
			next_scan_busy = 1'b0;
			next_gap_cnt   = '0;
			if (settle != SETTLE_CNT) begin
				next_settle   = settle + 1'b1;
				next_attn_ref = attn_s;
			end
			if (wake) begin
				next_pwr.power_mode = PS_ACTIVE;
			end
		end else begin
			next_settle = '0;
		end
		if (apb_wr && paddr == REG_PWR_OFS) begin
			next_pwr             = tpac_pwr_s'(pwdata);
			next_pwr.rsvd        = '0;
			next_pwr.rsvd3       = 1'b0;
			next_gap_cnt         = '0;
			next_idle_cnt        = '0;
			next_slow_shift      = '0;
		end else if (apb_wr && paddr == REG_ATT_OFS) begin
			next_att       = tpac_att_s'(pwdata);
			next_att.rsvd  = '0;
			next_att.rsvd2 = '0;
		end
		if (psel && !penable) begin
			if (paddr == REG_PWR_OFS) begin
				next_prdata = pwr;
			end else if (paddr == REG_ATT_OFS) begin
				next_prdata = att;
			end else if (paddr == REG_STAT_OFS) begin
				next_prdata = {25'h0, slow_shift, pend, hold, att_act, scan_busy};
			end else begin
				next_prdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr        <= PWR_RST;
			att        <= ATT_RST;
			prdata     <= 32'h0000_0000;
			scan_busy  <= 1'b0;
			scan_start <= 1'b0;
			gap_cnt    <= '0;
			idle_cnt   <= 8'h00;
			slow_shift <= 3'h0;
			settle     <= 5'h00;
			attn_ref   <= 1'b1;
		end else begin
			pwr        <= next_pwr;
			att        <= next_att;
			prdata     <= next_prdata;
			scan_busy  <= next_scan_busy;
			scan_start <= next_scan_start;
			gap_cnt    <= next_gap_cnt;
			idle_cnt   <= next_idle_cnt;
			slow_shift <= next_slow_shift;
			settle     <= next_settle;
			attn_ref   <= next_attn_ref;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial read completion watcher
	always_comb begin
		next_i2c_st  = i2c_st;
		next_bit_cnt = bit_cnt;
		next_rd_dir  = rd_dir;
		read_done    = 1'b0;
		if (scl_s && scl_d && sda_d && !sda_s) begin
			next_i2c_st  = IS_ADDR;
			next_bit_cnt = 4'h0;
		end else if (scl_s && scl_d && !sda_d && sda_s) begin
			read_done   = (i2c_st == IS_DATA) & rd_dir;
			next_i2c_st = IS_IDLE;
		end else if (scl_s && !scl_d && i2c_st == IS_ADDR) begin
			next_bit_cnt = bit_cnt + 1'b1;
			if (bit_cnt == 4'h7) begin
				next_rd_dir = sda_s;
				next_i2c_st = IS_DATA;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i2c_st  <= IS_IDLE;
			bit_cnt <= 4'h0;
			rd_dir  <= 1'b0;
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
		end else begin
			i2c_st  <= next_i2c_st;
			bit_cnt <= next_bit_cnt;
			rd_dir  <= next_rd_dir;
			scl_d   <= scl_s;
			sda_d   <= sda_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Attention line
	always_comb begin
		next_hold        = hold;
		next_pend        = pend;
		next_last_finger = last_finger;
		next_pulse_cnt   = pulse_cnt;
		if (pulse_cnt != '0) begin
			next_pulse_cnt = pulse_cnt - 1'b1;
		end
		if (read_done) begin
			next_pend = 1'b0;
			if (!last_finger) begin
				next_hold = 1'b0;
			end
		end
		if (scan_done && att.en_attn && !frozen) begin
			next_last_finger = scan_finger;
			case (att.att_mode)
				AM_PERIODIC: begin
					next_pulse_cnt = PULSE_W'(({8'h00, att.pulse_width} + 16'h0001)
						* PULSE_UNIT_CYCLES);
				end
				AM_MOVE: begin
					if (scan_moving || pend) begin
						next_pulse_cnt = PULSE_W'(({8'h00, att.pulse_width} + 16'h0001)
							* PULSE_UNIT_CYCLES);
					end
					if (scan_moving) begin
						next_pend = 1'b1;
					end
				end
				AM_TOUCH: begin
					if (scan_finger) begin
						next_hold = 1'b1;
						next_pend = 1'b1;
					end
				end
				default: begin
					next_hold = 1'b0;
				end
			endcase
		end
		if (frozen || !att.en_attn) begin
			next_hold      = 1'b0;
			next_pulse_cnt = '0;
		end
		next_attn_oe  = ~frozen;
		next_attn_out = att.attention_polarity ? att_act : ~att_act;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold        <= 1'b0;
			pend        <= 1'b0;
			last_finger <= 1'b0;
			pulse_cnt   <= '0;
			attn_out    <= 1'b1;
			attn_oe     <= 1'b1;
		end else begin
			hold        <= next_hold;
			pend        <= next_pend;
			last_finger <= next_last_finger;
			pulse_cnt   <= next_pulse_cnt;
			attn_out    <= next_attn_out;
			attn_oe     <= next_attn_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	deep_by_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pwr.power_mode == PS_DEEP) && !$past(pwr.power_mode == PS_DEEP) |-> $past(wr_pwr))
		else $error("deep sleep entered without host write");
	freeze_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		frozen ##1 frozen |-> !osc_run && !scan_start && !scan_busy)
		else $error("activity during freeze");
	rst_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		frozen && !rst_s && !wr_pwr |=> pwr.power_mode == PS_ACTIVE)
		else $error("reset pin did not wake");
	sleep_promote_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwr.power_mode == PS_SLEEP && pwr.allow_sleep && scan_done && scan_finger && !wr_pwr
		|=> pwr.power_mode == PS_ACTIVE)
		else $error("no promotion on finger");
	periodic_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		scan_done && att.en_attn && att.att_mode == AM_PERIODIC && !frozen && !apb_wr
		|=> att_act [*2])
		else $error("periodic pulse missing");
	touch_assert_a: assert property (@(posedge pclk) disable iff (!presetn)
		scan_done && scan_finger && att.en_attn && att.att_mode == AM_TOUCH && !frozen
		&& !apb_wr |=> hold ##1 (att.attention_polarity ? attn_out : !attn_out))
		else $error("touch did not assert attention");
	touch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		hold && !read_done && !frozen && att.en_attn && !apb_wr |=> hold)
		else $error("attention dropped before service");
	active_idle_scan_a: assert property (@(posedge pclk) disable iff (!presetn)
		next_scan_start && pwr.power_mode == PS_ACTIVE |-> !att_act)
		else $error("active scan while attention pending");
	polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(apb_wr) |-> attn_out == ($past(att.attention_polarity) ? $past(att_act)
		: !$past(att_act)))
		else $error("attention level wrong");
	deep_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		scan_done && pwr.power_mode == PS_DEEP && !wr_pwr |=> gap_cnt == DEEP_GAP)
		else $error("deep sleep rate wrong");

	promote_c: cover property (@(posedge pclk) disable iff (!presetn)
		pwr.power_mode == PS_SLEEP ##1 pwr.power_mode == PS_ACTIVE);
	demote_c: cover property (@(posedge pclk) disable iff (!presetn)
		pwr.power_mode == PS_ACTIVE ##1 pwr.power_mode == PS_SLEEP);
	attn_wake_c: cover property (@(posedge pclk) disable iff (!presetn)
		frozen && rst_s ##1 pwr.power_mode == PS_ACTIVE);
	serviced_c: cover property (@(posedge pclk) disable iff (!presetn)
		read_done && hold ##1 !hold);

endmodule

// ### tpac_host_model.sv
`timescale 1ns/1ps
module tpac_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value
) (
	output logic scl,
	output logic sda
);
	localparam realtime HALF = 62.5;

	// Link clock stands still and data is released high between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Start, address byte with read bit, released ack slot, stop
	task automatic read_report();
		logic [8:0] bits;
		bits = {DEV_ADDR, 1'b1, 1'b1};
		sda = 1'b0;
		#HALF;
		for (int i = 8; i >= 0; i--) begin
			scl = 1'b0;
			#(HALF / 2);
			sda = bits[i];
			#(HALF / 2);
			scl = 1'b1;
			#HALF;
		end
		scl = 1'b0;
		#(HALF / 2);
		sda = 1'b0;
		#(HALF / 2);
		scl = 1'b1;
		#HALF;
		sda = 1'b1;
		#HALF;
	endtask
endmodule

// ### tpac_ctrl_tb.sv
`timescale 1ns/1ps
module tpac_ctrl_tb
	import tpac_pkg::*;
;
	localparam int SLEEP_N = 200;
	localparam int DEEP_N  = 400;
	localparam int SLOW_N  = 20;

	logic        pclk        = 1'b0;
	logic        presetn     = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_w;
	logic        sda_w;
	logic        rst_pin_n   = 1'b1;
	logic        host_attn   = 1'b1;
	logic        attn_out;
	logic        attn_oe;
	logic        attn_wire;
	logic        scan_start;
	logic        scan_done   = 1'b0;
	logic        scan_finger = 1'b0;
	logic        scan_moving = 1'b0;
	logic        osc_run;
	logic [3:0]  lat         = 4'h0;
	int          start_cnt   = 0;
	int          error_cnt   = 0;
	int          compares    = 0;
	int          n;
	int          s0;
	logic [31:0] r;
	logic        e;

	always #5 pclk = ~pclk;

	// Wire level: released wire follows host_attn, which idles high
	assign attn_wire = attn_oe ? attn_out : host_attn;

	tpac_ctrl #(
		.SLEEP_CYCLES (SLEEP_N),
		.DEEP_CYCLES  (DEEP_N),
		.SLOW_BASE    (SLOW_N)
	) tpac_ctrl_i (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.scl_in      (scl_w),
		.sda_in      (sda_w),
		.rst_pin_n   (rst_pin_n),
		.attn_in     (attn_wire),
		.attn_out    (attn_out),
		.attn_oe     (attn_oe),
		.scan_start  (scan_start),
		.scan_done   (scan_done),
		.scan_finger (scan_finger),
		.scan_moving (scan_moving),
		.osc_run     (osc_run)
	);

	tpac_host_model tpac_host_model_i (
		.scl (scl_w),
		.sda (sda_w)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Scan engine: fixed ten cycle scan
	always @(posedge pclk) begin
		scan_done <= (lat == 4'h1);
		if (scan_start === 1'b1)
			lat <= 4'hA;
		else if (lat != 4'h0)
			lat <= lat - 4'h1;
		if (scan_start === 1'b1)
			start_cnt <= start_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(nm, exp, r);
	endtask

	task automatic wait_done();
		do @(posedge pclk); while (scan_done !== 1'b1);
	endtask

	task automatic gap();
		wait_done();
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (scan_start !== 1'b1);
	endtask

	task automatic attn_chk(input string nm, input logic exp);
		wait_done();
		repeat (5) @(posedge pclk);
		check(nm, 32'(exp), 32'(attn_out));
	endtask

	task automatic summarize();
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge pclk);
		error_cnt++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("power reset", REG_PWR_OFS, PWR_RST);
		rd_chk("attn reset", REG_ATT_OFS, ATT_RST);
		check("attn idle", 32'h1, 32'(attn_out));
		apb(1'b0, 8'h0C, 32'h0);
		check("unmapped err", 32'h1, 32'(e));
		check("unmapped data", 32'h0, r);
		// Attention off and a finger held, so no slowdown spaces the scans
		apb(1'b1, REG_ATT_OFS, 32'h0000_000B);
		scan_finger <= 1'b1;
		s0 = start_cnt;
		repeat (300) @(posedge pclk);
		scan_finger <= 1'b0;
		check("active scans", 32'h1, 32'(start_cnt - s0 >= 15));
		apb(1'b1, REG_ATT_OFS, ATT_RST);
		// Idle field 1, sleep allowed, active
		wait_done();
		apb(1'b1, REG_PWR_OFS, 32'h14);
		repeat (16) wait_done();
		rd_chk("still active", REG_PWR_OFS, 32'h14);
		rd_chk("slowdown", REG_STAT_OFS, {25'h0, SLOW_MAX, 4'h0});
		wait_done();
		repeat (3) @(posedge pclk);
		rd_chk("demoted", REG_PWR_OFS, 32'h15);
		scan_finger <= 1'b1;
		wait_done();
		repeat (3) @(posedge pclk);
		rd_chk("promoted", REG_PWR_OFS, 32'h14);
		// Touch mode in sleep without promotion; held attention does not pause sleep scans
		apb(1'b1, REG_PWR_OFS, 32'h01);
		attn_chk("touch attn", 1'b0);
		scan_finger <= 1'b0;
		gap();
		check("sleep gap", 32'h1, 32'(n >= SLEEP_N - 5 && n <= SLEEP_N + 5));
		attn_chk("touch held", 1'b0);
		tpac_host_model_i.read_report();
		repeat (30) @(posedge pclk);
		check("touch released", 32'h1, 32'(attn_out));
		// Deep sleep with finger and sleep allowed
		wait_done();
		apb(1'b1, REG_PWR_OFS, 32'h06);
		scan_finger <= 1'b1;
		gap();
		check("deep gap", 32'h1, 32'(n >= DEEP_N - 5 && n <= DEEP_N + 5));
		rd_chk("deep kept", REG_PWR_OFS, 32'h06);
		scan_finger <= 1'b0;
		// An empty scan first, so the service releases the held line
		wait_done();
		tpac_host_model_i.read_report();
		// Movement mode, one unit pulse
		apb(1'b1, REG_ATT_OFS, 32'h09);
		wait_done();
		apb(1'b1, REG_PWR_OFS, 32'h01);
		scan_finger <= 1'b1;
		scan_moving <= 1'b1;
		attn_chk("move attn", 1'b0);
		scan_finger <= 1'b0;
		scan_moving <= 1'b0;
		attn_chk("move pend", 1'b0);
		tpac_host_model_i.read_report();
		attn_chk("move stopped", 1'b1);
		// Periodic mode, active high, one unit pulse
		apb(1'b1, REG_ATT_OFS, 32'h0C);
		apb(1'b1, REG_PWR_OFS, 32'h00);
		do @(posedge pclk); while (attn_out !== 1'b1);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (attn_out === 1'b1);
		check("pulse width", 32'(PULSE_UNIT_CYCLES), 32'(n));
		// Freeze and both wake methods
		apb(1'b1, REG_ATT_OFS, 32'h1A);
		apb(1'b1, REG_PWR_OFS, 32'h03);
		repeat (5) @(posedge pclk);
		check("freeze osc", 32'h0, 32'(osc_run));
		check("freeze oe", 32'h0, 32'(attn_oe));
		s0 = start_cnt;
		repeat (100) @(posedge pclk);
		check("freeze scans", 32'(s0), 32'(start_cnt));
		rst_pin_n <= 1'b0;
		repeat (8) @(posedge pclk);
		rst_pin_n <= 1'b1;
		repeat (4) @(posedge pclk);
		check("pin wake", 32'h1, 32'(osc_run));
		rd_chk("pin wake state", REG_PWR_OFS, 32'h00);
		apb(1'b1, REG_PWR_OFS, 32'h03);
		repeat (30) @(posedge pclk);
		host_attn <= 1'b0;
		repeat (10) @(posedge pclk);
		check("edge wake", 32'h1, 32'(osc_run));
		host_attn <= 1'b1;
		repeat (10) @(posedge pclk);
		summarize();
	end
endmodule
